// ---- include/dsc_params.svh ----
// Constants for the two-wire DAC command slave
`ifndef DSC_PARAMS_SVH
`define DSC_PARAMS_SVH

// ----------------------------------------------------------------
// Fixed address bits six to one, one pattern per product variant
// ----------------------------------------------------------------
`define DSC_ADDR_VAR_L    6'h08
`define DSC_ADDR_VAR_M    6'h09
`define DSC_ADDR_VAR_N    6'h1A
`define DSC_ADDR_VAR_P    6'h2A

// ----------------------------------------------------------------
// Command field encodings
// ----------------------------------------------------------------
`define DSC_CMD_LOAD_BOTH 4'hC
`define DSC_CMD_LOAD_IN   4'hD
`define DSC_CMD_SWAP      4'hE
`define DSC_CMD_XFER      4'hF
`define DSC_PFX_READ      2'h2
`define DSC_PFX_PD        2'h1

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define DSC_CODE_RESET    10'h000
`define DSC_PD_RESET      2'h3
`define DSC_EN_RESET      1'h1

// ----------------------------------------------------------------
// Wishbone register byte offsets
// ----------------------------------------------------------------
`define DSC_OFS_CTRL      8'h00
`define DSC_OFS_STATUS    8'h04
`define DSC_OFS_INCODE    8'h08
`define DSC_OFS_OUTCODE   8'h0C
`define DSC_OFS_PDSEL     8'h10

`endif

// ---- include/dsc_pkg.sv ----
// Types shared by the two-wire DAC command slave
package dsc_pkg;

    typedef enum logic [2:0] {
        DSC_IDLE  = 3'h0,
        DSC_ADDR  = 3'h1,
        DSC_AACK  = 3'h2,
        DSC_WBYTE = 3'h3,
        DSC_WACK  = 3'h4,
        DSC_RBYTE = 3'h5,
        DSC_RACK  = 3'h6
    } dsc_state_type;

    typedef struct packed {
        logic [9:0] input_code;
        logic [9:0] output_code;
        logic [1:0] powerdown_select;
    } dsc_dac_type;

    typedef struct packed {
        dsc_state_type st;
        logic [1:0]    scl_sy;
        logic [1:0]    sda_sy;
        logic [1:0]    strap_sy;
        logic          scl_d;
        logic          sda_d;
        logic [3:0]    cnt;
        logic [7:0]    sh;
        logic [7:0]    b0;
        logic          rw;
        logic          bidx;
        logic          hold_start;
        logic          nack;
        logic          oe_n;
        logic [9:0]    in_code;
        logic [9:0]    out_code;
        logic [1:0]    pd;
        logic          en;
        logic          ack;
        logic [31:0]   dat;
    } dsc_regs_type;

endpackage

// ---- logic/dsc_slave.sv ----
// Two-wire serial command slave of a 10-bit DAC with Wishbone access
//
// Behaviour
// - Address bits six to one are a fixed pattern chosen per variant.
// - Address bit zero follows the level of the address strap pin.
// - Address bits compared one by one; first mismatch drops the transfer.
// - Last bit of address byte: zero means write, one means read.
// - Matching address is acknowledged by SDA low for the ninth clock.
// - Code registers change only on the fall ending the last acknowledge.
// - An aborted write changes nothing; master repeats the whole write.
// - Command 1100 loads the code into input and output registers.
// - Command 1101 loads the input register only; output holds.
// - Command 1110 moves old input to output, then loads new input.
// - Command 1111 moves input to output and ignores the code bits.
// - Command 10xx is a read request; code bits ignored, nothing changes.
// - Command 01xx stores code bits nine and eight as power-down select.
// - In read mode the slave drives SDA after its address acknowledge.
// - Read sends byte one, waits for master acknowledge, then byte two.
// - The general call address is never acknowledged.
// - Only 7-bit addressing; 10-bit sequences never address this slave.
// - After mismatch the serial clock is ignored until a valid start.
// - Reset clears both code registers and selects 100k power-down.
// - Power-down keeps both code registers unchanged.
// - Stop ends a transfer anywhere, unless in the same high as start.
`timescale 1ns/1ns
`include "dsc_params.svh"

module dsc_slave #(
    parameter logic [5:0] ADDR_HI = `DSC_ADDR_VAR_L
) (
    input  wire logic                clk,
    input  wire logic                sys_rst,
    input  wire logic                scl,
    input  wire logic                sda_in,
    output logic                     sda_out,
    output logic                     sda_oe_n,
    input  wire logic                address_strap_bit,
    output dsc_pkg::dsc_dac_type     dac,
    input  wire logic                wb_cyc,
    input  wire logic                wb_stb,
    input  wire logic                wb_we,
    input  wire logic [7:0]          wb_adr,
    input  wire logic [3:0]          wb_sel,
    input  wire logic [31:0]         wb_dat_w,
    output logic [31:0]              wb_dat_r,
    output logic                     wb_ack
);

    // ------------------------------------------------------------
    // State and line events
    // ------------------------------------------------------------
    dsc_pkg::dsc_regs_type r_r;
    dsc_pkg::dsc_regs_type r_nxt;

    logic        scl_rise;
    logic        scl_fall;
    logic        start_c;
    logic        stop_c;
    logic        sda_bit;
    logic [6:0]  my_addr;
    logic        exp_bit;
    logic        apply;
    logic [15:0] wr_word;
    logic [3:0]  cmd;
    logic [9:0]  code;
    logic [1:0]  pd_new;
    logic [15:0] rd_word;
    logic        wb_req;

    function automatic logic addr_bit(input logic [6:0] a,
                                      input logic [3:0] idx);
        logic [2:0] k;
        k = 3'h6 - idx[2:0];
        return a[k];
    endfunction

    function automatic logic [7:0] rd_byte(input logic [15:0] w,
                                           input logic        sel);
        return sel ? w[7:0] : w[15:8];
    endfunction

    assign scl_rise = r_r.scl_sy[1] & ~r_r.scl_d;
    assign scl_fall = ~r_r.scl_sy[1] & r_r.scl_d;
    assign start_c  = r_r.scl_sy[1] & r_r.scl_d & r_r.sda_d
                      & ~r_r.sda_sy[1];
    assign stop_c   = r_r.scl_sy[1] & r_r.scl_d & ~r_r.sda_d
                      & r_r.sda_sy[1];
    assign sda_bit  = r_r.sda_sy[1];
    assign my_addr  = {ADDR_HI, r_r.strap_sy[1]};
    assign exp_bit  = addr_bit(my_addr, r_r.cnt);
    assign apply    = (r_r.st == dsc_pkg::DSC_WACK) & scl_fall & r_r.bidx
                      & ~start_c & ~(stop_c & ~r_r.hold_start);
    assign wr_word  = {r_r.b0, r_r.sh};
    assign cmd      = wr_word[15:12];
    assign code     = wr_word[11:2];
    assign pd_new   = code[9:8];
    // Read-back word: power-down select in the low command bits
    assign rd_word  = {2'h0, r_r.pd, r_r.out_code, 2'h0};
    assign wb_req   = wb_cyc & wb_stb & ~r_r.ack;

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        r_nxt          = r_r;
        r_nxt.scl_sy   = {r_r.scl_sy[0], scl};
        r_nxt.sda_sy   = {r_r.sda_sy[0], sda_in};
        r_nxt.strap_sy = {r_r.strap_sy[0], address_strap_bit};
        r_nxt.scl_d    = r_r.scl_sy[1];
        r_nxt.sda_d    = r_r.sda_sy[1];

        // Wishbone slave, one wait state, zero for unmapped reads
        r_nxt.ack = wb_req;
        if (wb_req) begin
            unique case (wb_adr)
                `DSC_OFS_CTRL:    r_nxt.dat = {31'h0, r_r.en};
                `DSC_OFS_STATUS:  r_nxt.dat = {20'h0, r_r.rw, r_r.st,
                                               1'b0, my_addr};
                `DSC_OFS_INCODE:  r_nxt.dat = {22'h0, r_r.in_code};
                `DSC_OFS_OUTCODE: r_nxt.dat = {22'h0, r_r.out_code};
                `DSC_OFS_PDSEL:   r_nxt.dat = {30'h0, r_r.pd};
                default:          r_nxt.dat = 32'h0;
            endcase
            if (wb_we && wb_sel[0] && wb_adr == `DSC_OFS_CTRL) begin
                r_nxt.en = wb_dat_w[0];
            end
        end

        // Serial engine
        if (start_c && r_r.en) begin
            r_nxt.st         = dsc_pkg::DSC_ADDR;
            r_nxt.cnt        = 4'h0;
            r_nxt.oe_n       = 1'b1;
            r_nxt.hold_start = 1'b1;
            r_nxt.bidx       = 1'b0;
        end else if (stop_c && !r_r.hold_start) begin
            r_nxt.st   = dsc_pkg::DSC_IDLE;
            r_nxt.oe_n = 1'b1;
        end else if (r_r.st != dsc_pkg::DSC_IDLE) begin
            if (scl_fall) begin
                r_nxt.hold_start = 1'b0;
            end
            unique case (r_r.st)
                dsc_pkg::DSC_ADDR: begin
                    if (scl_rise) begin
                        r_nxt.sh  = {r_r.sh[6:0], sda_bit};
                        r_nxt.cnt = r_r.cnt + 4'h1;
                        if (r_r.cnt < 4'h7 && sda_bit != exp_bit) begin
                            // Ignored until next start
                            r_nxt.st = dsc_pkg::DSC_IDLE;
                        end
                        if (r_r.cnt == 4'h7) begin
                            r_nxt.rw = sda_bit;
                        end
                    end else if (scl_fall && r_r.cnt == 4'h8) begin
                        r_nxt.oe_n = 1'b0;
                        r_nxt.st   = dsc_pkg::DSC_AACK;
                        r_nxt.cnt  = 4'h0;
                    end
                end
                dsc_pkg::DSC_AACK: begin
                    if (scl_fall) begin
                        r_nxt.bidx = 1'b0;
                        if (r_r.rw) begin
                            r_nxt.st   = dsc_pkg::DSC_RBYTE;
                            r_nxt.sh   = rd_byte(rd_word, 1'b0);
                            r_nxt.oe_n = rd_word[15];
                        end else begin
                            r_nxt.st   = dsc_pkg::DSC_WBYTE;
                            r_nxt.oe_n = 1'b1;
                        end
                    end
                end
                dsc_pkg::DSC_WBYTE: begin
                    if (scl_rise) begin
                        r_nxt.sh  = {r_r.sh[6:0], sda_bit};
                        r_nxt.cnt = r_r.cnt + 4'h1;
                    end else if (scl_fall && r_r.cnt == 4'h8) begin
                        r_nxt.oe_n = 1'b0;
                        r_nxt.st   = dsc_pkg::DSC_WACK;
                        r_nxt.cnt  = 4'h0;
                        if (!r_r.bidx) begin
                            r_nxt.b0 = r_r.sh;
                        end
                    end
                end
                dsc_pkg::DSC_WACK: begin
                    if (scl_fall) begin
                        r_nxt.oe_n = 1'b1;
                        r_nxt.st   = dsc_pkg::DSC_WBYTE;
                        r_nxt.bidx = ~r_r.bidx;
                    end
                    // Commit only at the fall closing the second ack
                    if (apply) begin
                        if (cmd == `DSC_CMD_LOAD_BOTH) begin
                            r_nxt.in_code  = code;
                            r_nxt.out_code = code;
                        end else if (cmd == `DSC_CMD_LOAD_IN) begin
                            r_nxt.in_code = code;
                        end else if (cmd == `DSC_CMD_SWAP) begin
                            r_nxt.out_code = r_r.in_code;
                            r_nxt.in_code  = code;
                        end else if (cmd == `DSC_CMD_XFER) begin
                            r_nxt.out_code = r_r.in_code;
                        end else if (cmd[3:2] == `DSC_PFX_PD) begin
                            r_nxt.pd = pd_new;
                        end
                        // Read prefix leaves everything as is
                    end
                end
                dsc_pkg::DSC_RBYTE: begin
                    if (scl_rise) begin
                        r_nxt.cnt = r_r.cnt + 4'h1;
                    end else if (scl_fall && r_r.cnt == 4'h8) begin
                        r_nxt.oe_n = 1'b1;
                        r_nxt.st   = dsc_pkg::DSC_RACK;
                        r_nxt.cnt  = 4'h0;
                    end else if (scl_fall) begin
                        r_nxt.sh   = {r_r.sh[6:0], 1'b0};
                        r_nxt.oe_n = r_r.sh[6];
                    end
                end
                dsc_pkg::DSC_RACK: begin
                    if (scl_rise) begin
                        r_nxt.nack = sda_bit;
                    end else if (scl_fall) begin
                        if (r_r.nack) begin
                            r_nxt.st = dsc_pkg::DSC_IDLE;
                        end else begin
                            r_nxt.st   = dsc_pkg::DSC_RBYTE;
                            r_nxt.bidx = ~r_r.bidx;
                            r_nxt.sh   = rd_byte(rd_word, ~r_r.bidx);
                            r_nxt.oe_n = r_nxt.sh[7];
                        end
                    end
                end
                default: begin
                    r_nxt.st   = dsc_pkg::DSC_IDLE;
                    r_nxt.oe_n = 1'b1;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // State register
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            r_r          <= '0;
            r_r.st       <= dsc_pkg::DSC_IDLE;
            r_r.scl_sy   <= 2'h3;
            r_r.sda_sy   <= 2'h3;
            r_r.scl_d    <= 1'b1;
            r_r.sda_d    <= 1'b1;
            r_r.oe_n     <= 1'b1;
            r_r.in_code  <= `DSC_CODE_RESET;
            r_r.out_code <= `DSC_CODE_RESET;
            r_r.pd       <= `DSC_PD_RESET;
            r_r.en       <= `DSC_EN_RESET;
        end else begin
            r_r <= r_nxt;
        end
    end

    assign sda_out  = 1'b0;
    assign sda_oe_n = r_r.oe_n;
    assign dac      = {r_r.in_code, r_r.out_code, r_r.pd};
    assign wb_dat_r = r_r.dat;
    assign wb_ack   = r_r.ack;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (sys_rst);

    addr_ack_a: assert property (
        r_r.st == dsc_pkg::DSC_ADDR && scl_fall && r_r.cnt == 4'h8
        |=> !r_r.oe_n && r_r.st == dsc_pkg::DSC_AACK)
        else $error("address acknowledge not driven");
    addr_miss_a: assert property (
        r_r.st == dsc_pkg::DSC_ADDR && scl_rise && r_r.cnt < 4'h7
        && sda_bit != exp_bit |=> r_r.st == dsc_pkg::DSC_IDLE)
        else $error("address mismatch not dropped");
    idle_quiet_a: assert property (
        r_r.st == dsc_pkg::DSC_IDLE && !start_c
        |=> r_r.st == dsc_pkg::DSC_IDLE && r_r.oe_n)
        else $error("idle slave reacted to clock");
    upd_point_a: assert property (
        $changed(r_r.out_code) || $changed(r_r.in_code) |-> $past(apply))
        else $error("code register changed outside commit");
    load_both_a: assert property (
        apply && cmd == `DSC_CMD_LOAD_BOTH
        |=> r_r.out_code == $past(code) && r_r.in_code == $past(code))
        else $error("load both wrong");
    load_in_a: assert property (
        apply && cmd == `DSC_CMD_LOAD_IN
        |=> $stable(r_r.out_code) && r_r.in_code == $past(code))
        else $error("load input wrong");
    swap_load_a: assert property (
        apply && cmd == `DSC_CMD_SWAP
        |=> r_r.out_code == $past(r_r.in_code)
        && r_r.in_code == $past(code))
        else $error("swap load wrong");
    xfer_only_a: assert property (
        apply && cmd == `DSC_CMD_XFER
        |=> r_r.out_code == $past(r_r.in_code) && $stable(r_r.in_code))
        else $error("transfer wrong");
    read_req_a: assert property (
        apply && cmd[3:2] == `DSC_PFX_READ
        |=> $stable(r_r.out_code) && $stable(r_r.pd))
        else $error("read request changed state");
    pd_load_a: assert property (
        apply && cmd[3:2] == `DSC_PFX_PD |=> r_r.pd == $past(pd_new))
        else $error("power-down select wrong");
    read_drive_a: assert property (
        r_r.st == dsc_pkg::DSC_AACK && scl_fall && r_r.rw
        |=> r_r.st == dsc_pkg::DSC_RBYTE && r_r.oe_n == $past(rd_word[15]))
        else $error("read data not driven");
    stop_end_a: assert property (
        stop_c && !r_r.hold_start && !start_c
        |=> r_r.st == dsc_pkg::DSC_IDLE ##1 r_r.oe_n)
        else $error("stop did not end transfer");
    por_state_a: assert property (
        $fell(sys_rst) |-> r_r.pd == `DSC_PD_RESET
        && r_r.out_code == `DSC_CODE_RESET
        && r_r.in_code == `DSC_CODE_RESET)
        else $error("reset values wrong");

    write_cmd_c: cover property (apply);
    read_two_c:  cover property (r_r.st == dsc_pkg::DSC_RACK && scl_fall
                                 && r_r.bidx);
    miss_c:      cover property (r_r.st == dsc_pkg::DSC_ADDR && scl_rise
                                 && sda_bit != exp_bit);

endmodule

// ---- verification/dac_serial_command_slave_tb.sv ----
// Self-checking bench of the two-wire DAC command slave
`timescale 1ns/1ns
`include "dsc_params.svh"

module dac_serial_command_slave_tb;
    localparam logic [5:0] AHI = `DSC_ADDR_VAR_N;
    localparam logic [7:0] BAD [3] = '{{AHI, 2'h0} ^ 8'h20, 8'h00, 8'hF0};

    logic                 clk = 1'h0;
    logic                 sys_rst = 1'h1;
    logic                 strap = 1'h0;
    logic                 wb_cyc = 1'h0;
    logic                 wb_stb = 1'h0;
    logic                 wb_we = 1'h0;
    logic [7:0]           wb_adr = 8'h00;
    logic [3:0]           wb_sel = 4'h0;
    logic [31:0]          wb_dat_w = 32'h00000000;
    logic [31:0]          wb_dat_r;
    logic                 wb_ack;
    logic                 scl;
    logic                 sda_pull;
    logic                 sda_out;
    logic                 sda_oe_n;
    wire                  sda;
    dsc_pkg::dsc_dac_type dac;
    logic [21:0]          exp_st;
    logic [31:0]          seed = 32'h00000063;
    int                   n_fail = 0;
    int                   checks = 0;

    // Pulled-up open-drain line shared by master and slave
    assign sda = ~sda_pull & (sda_oe_n | sda_out);

    always #5 clk = ~clk;

    dsc_slave #(.ADDR_HI(AHI)) dut (
        .clk(clk), .sys_rst(sys_rst), .scl(scl), .sda_in(sda),
        .sda_out(sda_out), .sda_oe_n(sda_oe_n),
        .address_strap_bit(strap), .dac(dac), .wb_cyc(wb_cyc),
        .wb_stb(wb_stb), .wb_we(wb_we), .wb_adr(wb_adr),
        .wb_sel(wb_sel), .wb_dat_w(wb_dat_w), .wb_dat_r(wb_dat_r),
        .wb_ack(wb_ack)
    );

    dsc_master_model m (.scl(scl), .sda_pull(sda_pull), .sda(sda));

    // ----------------------------------------------------------------
    // Checking, reporting and expectations
    // ----------------------------------------------------------------
    task automatic chk(input string nm, input logic [31:0] seen,
                       input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic end_test(input string nm);
        $display("test %s done", nm);
    endtask

    task automatic give_verdict();
        $display("checks %0d n_fail %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    function automatic logic [31:0] xs(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        return s ^ (s << 5);
    endfunction

    // State is {input code, output code, power-down select}
    function automatic logic [21:0] nxt(input logic [21:0] s,
                                        input logic [15:0] w);
        case (w[15:12])
            4'hC: return {w[11:2], w[11:2], s[1:0]};
            4'hD: return {w[11:2], s[11:0]};
            4'hE: return {w[11:2], s[21:12], s[1:0]};
            4'hF: return {s[21:12], s[21:12], s[1:0]};
            default: return (w[15:14] == 2'h1) ? {s[21:2], w[11:10]} : s;
        endcase
    endfunction

    // ----------------------------------------------------------------
    // Bus access tasks
    // ----------------------------------------------------------------
    task automatic wb(input logic we, input logic [7:0] a,
                      input logic [31:0] d, output logic [31:0] q);
        int n;
        n = 0;
        @(posedge clk);
        wb_cyc <= 1'h1;
        wb_stb <= 1'h1;
        wb_we <= we;
        wb_adr <= a;
        wb_sel <= 4'h1;
        wb_dat_w <= d;
        do begin
            @(posedge clk);
            n++;
        end while (wb_ack !== 1'h1 && n < 50);
        q = wb_dat_r;
        if (n >= 50) n_fail++;
        wb_cyc <= 1'h0;
        wb_stb <= 1'h0;
        @(posedge clk);
    endtask

    // Address byte, then nb bytes of the word, then stop
    task automatic frame(input logic [7:0] a, input logic [15:0] w,
                         input int nb, output logic [2:0] ak);
        ak = 3'h0;
        m.start();
        m.send8(a, ak[2]);
        if (nb > 0) m.send8(w[15:8], ak[1]);
        if (nb > 1) m.send8(w[7:0], ak[0]);
        m.stop();
        repeat (8) @(posedge clk);
    endtask

    // ----------------------------------------------------------------
    // Test sequence
    // ----------------------------------------------------------------
    initial begin
        logic [31:0] q;
        logic [2:0]  ak;
        logic [7:0]  own;
        logic [7:0]  b0;
        logic [7:0]  b1;
        logic [15:0] w;
        exp_st = {10'h000, 10'h000, 2'h3};
        own = {AHI, 2'h0};
        repeat (16) @(posedge clk);
        sys_rst <= 1'h0;
        repeat (4) @(posedge clk);
        chk("dac reset", dac, exp_st);
        wb(1'h0, `DSC_OFS_STATUS, 32'h00000000, q);
        chk("own address", q[6:0], {AHI, 1'h0});
        wb(1'h0, 8'h40, 32'h00000000, q);
        chk("unmapped read", q, 32'h00000000);
        end_test("reset");
        for (int i = 0; i < 14; i++) begin
            seed = xs(seed);
            w = {i < 4 ? {2'h3, i[1:0]} : seed[15:12], seed[9:0], 2'h0};
            frame(own, w, 2, ak);
            exp_st = nxt(exp_st, w);
            chk("write acks", ak, 3'h7);
            chk("dac write", dac, exp_st);
            chk("line idle", sda_oe_n, 1'h1);
        end
        for (int p = 0; p < 4; p++) begin
            w = {4'h4, p[1:0], 8'hA5, 2'h0};
            frame(own, w, 2, ak);
            exp_st = nxt(exp_st, w);
            chk("power select", dac, exp_st);
        end
        end_test("writes");
        w = {4'hC, 10'h2B7, 2'h0};
        frame(own, w, 2, ak);
        exp_st = nxt(exp_st, w);
        frame(own, {4'h8, 10'h155, 2'h0}, 2, ak);
        chk("read request", dac, exp_st);
        m.start();
        m.send8(own | 8'h01, ak[0]);
        m.recv8(1'h1, b0);
        m.recv8(1'h0, b1);
        m.stop();
        chk("read ack", ak[0], 1'h1);
        chk("read word", {b0, b1},
            {2'h0, exp_st[1:0], exp_st[11:2], 2'h0});
        end_test("read");
        for (int k = 0; k < 2; k++) begin
            frame(own, {4'hC, 10'h3FF, 2'h0}, k, ak);
            chk("aborted write", dac, exp_st);
        end
        for (int j = 0; j < 3; j++) begin
            frame(BAD[j], {4'hC, 10'h111, 2'h0}, 2, ak);
            chk("foreign address", ak, 3'h0);
            chk("dac untouched", dac, exp_st);
        end
        end_test("refusals");
        strap <= 1'h1;
        repeat (4) @(posedge clk);
        w = {4'hC, 10'h0F0, 2'h0};
        frame(own, w, 2, ak);
        chk("old strap", ak, 3'h0);
        frame(own | 8'h02, w, 2, ak);
        exp_st = nxt(exp_st, w);
        chk("strap address", ak, 3'h7);
        chk("dac strap", dac, exp_st);
        wb(1'h1, `DSC_OFS_CTRL, 32'h00000000, q);
        frame(own | 8'h02, {4'hC, 10'h001, 2'h0}, 2, ak);
        chk("disabled", ak, 3'h0);
        chk("dac disabled", dac, exp_st);
        wb(1'h1, `DSC_OFS_CTRL, 32'h00000001, q);
        wb(1'h0, `DSC_OFS_OUTCODE, 32'h00000000, q);
        chk("output code", q, {22'h000000, exp_st[11:2]});
        wb(1'h0, `DSC_OFS_INCODE, 32'h00000000, q);
        chk("input code", q, {22'h000000, exp_st[21:12]});
        wb(1'h0, `DSC_OFS_PDSEL, 32'h00000000, q);
        chk("power select reg", q, {30'h00000000, exp_st[1:0]});
        end_test("registers");
        give_verdict();
    end

    // About four times the length of the whole sequence
    initial begin
        #400000;
        n_fail++;
        give_verdict();
    end
endmodule

// ---- verification/dsc_master_model.sv ----
// Behavioural two-wire bus master that drives the serial slave
`timescale 1ns/1ns

module dsc_master_model (
    output logic      scl,
    output logic      sda_pull,
    input  wire logic sda
);
    // Bus idles released, clock high and still between frames
    initial begin
        scl = 1'h1;
        sda_pull = 1'h0;
    end

    // ----------------------------------------------------------------
    // Bit slot of 125 ns: data moves mid-low, sampled mid-high
    // ----------------------------------------------------------------
    task automatic bit_io(input logic b, output logic r);
        #31 sda_pull = ~b;
        #31 scl = 1'h1;
        #31 r = sda;
        #32 scl = 1'h0;
    endtask

    // Start or repeated start, clock left low; the extra 1 ns keeps
    // every later pin change off the rising clock edge
    task automatic start();
        #32 sda_pull = 1'h0;
        #31 scl = 1'h1;
        #31 sda_pull = 1'h1;
        #32 scl = 1'h0;
    endtask

    // Stop, then the bus stands released
    task automatic stop();
        #31 sda_pull = 1'h1;
        #31 scl = 1'h1;
        #31 sda_pull = 1'h0;
        #32;
    endtask

    // ----------------------------------------------------------------
    // Byte transfers, most significant bit first
    // ----------------------------------------------------------------
    task automatic send8(input logic [7:0] d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_io(d[i], r);
        end
        bit_io(1'h1, r);
        ack = ~r;
    endtask

    // Our own acknowledge follows; a not-acknowledge ends a read
    task automatic recv8(input logic ack, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_io(1'h1, d[i]);
        end
        bit_io(~ack, r);
    endtask
endmodule
